// ===== rtl/ppc_pkg.sv
// Purpose: shared constants and types for the phy basic control block
// Assumes: 200 MHz system clock, clause 22 management frames
// Notes:   one register at management address 0x0

package ppc_pkg;

   // register map
   localparam logic [4:0]  PPC_ADDR_BASIC_CONTROL = 5'h00;
   localparam logic [15:0] PPC_BASIC_CONTROL_RESET = 16'h1100;

   // field positions of phy_basic_control
   localparam int PPC_BIT_SOFT_RESET     = 15;
   localparam int PPC_BIT_PCS_LOOPBACK   = 14;
   localparam int PPC_BIT_SPEED_LOW      = 13;
   localparam int PPC_BIT_AUTONEG_ENABLE = 12;
   localparam int PPC_BIT_POWER_DOWN     = 11;
   localparam int PPC_BIT_MAC_ISOLATE    = 10;
   localparam int PPC_BIT_DUPLEX_MODE    = 8;
   localparam int PPC_BIT_COLLISION_TEST = 7;
   localparam int PPC_BIT_SPEED_HIGH     = 6;
   localparam int PPC_BIT_ONE_WAY        = 5;

   // reset values of the loopback, autoneg and isolate fields and of the fixed duplex bit
   localparam logic PPC_RST_PCS_LOOPBACK   = 1'b0;
   localparam logic PPC_RST_AUTONEG_ENABLE = 1'b1;
   localparam logic PPC_RST_MAC_ISOLATE    = 1'b0;
   localparam logic PPC_RST_DUPLEX_MODE    = 1'b1;

   // soft reset cycle length
   localparam int PPC_SOFT_RESET_NS = 1000;
   localparam int PPC_CLK_MHZ       = 200;
   localparam int PPC_SOFT_RESET_CYCLES =
      (PPC_SOFT_RESET_NS * PPC_CLK_MHZ + 999) / 1000;
   localparam logic [7:0] PPC_SOFT_RESET_LAST =
      8'(PPC_SOFT_RESET_CYCLES - 1);

   // management frame layout
   localparam logic [5:0] PPC_PREAMBLE_ONES = 6'h20;
   localparam logic [3:0] PPC_HDR_LAST      = 4'hb;
   localparam logic [3:0] PPC_DATA_LAST     = 4'hf;
   localparam logic [1:0] PPC_OP_READ       = 2'h2;
   localparam logic [1:0] PPC_OP_WRITE      = 2'h1;

   // strap capture delay after reset release (synchroniser depth)
   localparam logic [1:0] PPC_STRAP_WAIT = 2'h2;

   // mirrored bit selector for the vendor / clause 45 access port
   typedef enum logic [1:0]
   {
      MIR_SOFT_RESET,
      MIR_PCS_LOOPBACK,
      MIR_AUTONEG_ENABLE,
      MIR_POWER_DOWN
   } ppc_mirror_type;

endpackage

// ===== rtl/ppc_mgmt_if.sv
// Purpose: register access between frame engine and control bank
// Assumes: single clock domain
// Notes:   wr is a one-cycle pulse, rdata follows addr combinationally

`timescale 1ns/1ps

interface ppc_mgmt_if;
   logic        wr;
   logic [4:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;

   modport engine
   (
      output wr,
      output addr,
      output wdata,
      input  rdata
   );

   modport bank
   (
      input  wr,
      input  addr,
      input  wdata,
      output rdata
   );
endinterface

// ===== rtl/ppc_ctrl_bank.sv
// Purpose: storage of phy_basic_control and its mirrored bits
// Assumes: strap value arrives already synchronised
// Notes:   mirror writes win over same-cycle management writes, except at soft reset, where a one from either write starts the cycle

`timescale 1ns/1ps

module ppc_ctrl_bank
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic           i_clk,
   input  wire logic           i_rst,
   // management access
   ppc_mgmt_if.bank            mg,
   // mirrored bit access
   input  wire logic           i_mir_wr,
   input  wire ppc_mirror_type i_mir_sel,
   input  wire logic           i_mir_bit,
   // strap
   input  wire logic           i_strap_load,
   input  wire logic           i_strap_value,
   // control outputs
   output logic                o_soft_reset,
   output logic                o_pcs_loopback,
   output logic                o_autoneg_enable,
   output logic                o_power_down,
   output logic                o_mac_isolate
);

   logic       strap_pd;
   logic       rst_busy;
   logic [7:0] rst_cnt;
   logic       reg_wr;
   logic       start;
   logic       done;

   function automatic logic mir_hit(input ppc_mirror_type s);
      return i_mir_wr && (i_mir_sel == s);
   endfunction

   assign reg_wr = mg.wr && (mg.addr == PPC_ADDR_BASIC_CONTROL);
   assign start  = (reg_wr && mg.wdata[PPC_BIT_SOFT_RESET])
                || (mir_hit(MIR_SOFT_RESET) && i_mir_bit); // R1 R12
   assign done   = rst_busy && (rst_cnt == PPC_SOFT_RESET_LAST);

   // strap held so a soft reset can restore it
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         strap_pd <= 1'b0;
      else if (i_strap_load)
         strap_pd <= i_strap_value; // R5
   end

   // soft reset cycle, bit clears itself when finished
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rst_busy <= 1'b0;
         rst_cnt  <= 8'h00;
      end
      else if (done)
      begin
         rst_busy <= 1'b0; // R1
         rst_cnt  <= 8'h00;
      end
      else if (rst_busy)
         rst_cnt <= rst_cnt + 8'h01;
      else if (start)
         rst_busy <= 1'b1; // R1
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_pcs_loopback <= PPC_RST_PCS_LOOPBACK;
      else if (done)
         o_pcs_loopback <= PPC_RST_PCS_LOOPBACK; // R2
      else if (mir_hit(MIR_PCS_LOOPBACK))
         o_pcs_loopback <= i_mir_bit; // R12
      else if (reg_wr)
         o_pcs_loopback <= mg.wdata[PPC_BIT_PCS_LOOPBACK]; // R2
   end

   // not writable through phy_basic_control, only through its mirror
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_autoneg_enable <= PPC_RST_AUTONEG_ENABLE; // R3
      else if (done)
         o_autoneg_enable <= PPC_RST_AUTONEG_ENABLE; // R3
      else if (mir_hit(MIR_AUTONEG_ENABLE))
         o_autoneg_enable <= i_mir_bit; // R12
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_power_down <= 1'b0;
      else if (i_strap_load)
         o_power_down <= i_strap_value; // R5
      else if (done)
         o_power_down <= strap_pd; // R5
      else if (mir_hit(MIR_POWER_DOWN))
         o_power_down <= i_mir_bit; // R12
      else if (reg_wr)
         o_power_down <= mg.wdata[PPC_BIT_POWER_DOWN]; // R4
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_mac_isolate <= PPC_RST_MAC_ISOLATE;
      else if (done)
         o_mac_isolate <= PPC_RST_MAC_ISOLATE; // R6
      else if (reg_wr)
         o_mac_isolate <= mg.wdata[PPC_BIT_MAC_ISOLATE]; // R6
   end

   assign o_soft_reset = rst_busy;

   // fixed fields and reserved bits are constants in the read word
   always_comb
   begin
      mg.rdata = 16'h0000; // R7 R8 R9 R10 R14
      if (mg.addr == PPC_ADDR_BASIC_CONTROL) // R11
      begin
         mg.rdata[PPC_BIT_SOFT_RESET]     = rst_busy;
         mg.rdata[PPC_BIT_PCS_LOOPBACK]   = o_pcs_loopback;
         mg.rdata[PPC_BIT_AUTONEG_ENABLE] = o_autoneg_enable;
         mg.rdata[PPC_BIT_POWER_DOWN]     = o_power_down;
         mg.rdata[PPC_BIT_MAC_ISOLATE]    = o_mac_isolate;
         mg.rdata[PPC_BIT_DUPLEX_MODE]    = PPC_RST_DUPLEX_MODE; // R7
      end
   end

endmodule

// ===== rtl/ppc_phy_basic_control.sv
// Purpose: clause 22 management slave holding phy_basic_control
// Assumes: mdc far slower than i_clk (at least 8 clocks per half period)
// Notes:   other management addresses read as zero, writes ignored
//
// Summary of operation
// R1: a one written to bit 15 starts a soft reset; the bit clears when done.
// R2: bit 14 is a read/write pcs loopback enable that resets to zero.
// R3: bit 12 reports autoneg enable, resets to one and is read-only here.
// R4: bit 11 selects soft power-down while management access keeps working.
// R5: the power-down reset value comes from the strap on the rx-valid pin.
// R6: bit 10 isolates the phy from its mac interface and resets to zero.
// R7: bit 8 always reads one for full duplex and ignores writes.
// R8: bit 7 always reads zero and ignores writes.
// R9: speed bits 6 and 13 always read 00 for 10 Mbps and ignore writes.
// R10: bit 5 always reads zero and ignores writes.
// R11: register at management address 0x0, reset 0x1100 save the strap bit.
// R12: reset, loopback, autoneg and power-down bits share their mirrors.
// R13: the host updates this register by read-modify-write.
// R14: reserved bit 9 and bits 4 to 0 read zero and ignore writes.

`timescale 1ns/1ps

module ppc_phy_basic_control
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic           i_clk,
   input  wire logic           i_rst,
   // management pins
   input  wire logic           i_mdc,
   input  wire logic           i_mdio,
   output logic                o_mdio,
   output logic                o_mdio_oe,
   input  wire logic [4:0]     i_phy_addr,
   // strap pin
   input  wire logic           i_power_down_strap_pin,
   // mirrored bit access
   input  wire logic           i_mir_wr,
   input  wire ppc_mirror_type i_mir_sel,
   input  wire logic           i_mir_bit,
   // control outputs
   output logic                o_soft_reset,
   output logic                o_pcs_loopback,
   output logic                o_autoneg_enable,
   output logic                o_power_down,
   output logic                o_mac_isolate
);

   typedef enum
   {
      ST_PREAMBLE,
      ST_START,
      ST_HEADER,
      ST_TURN,
      ST_DATA
   } ppc_state_type;

   ppc_mgmt_if mg ();

   // synchronisers
   logic [1:0]    mdc_sync;
   logic [1:0]    mdio_sync;
   logic [1:0]    strap_sync;
   logic [4:0]    addr_meta;
   logic [4:0]    addr_sync;
   logic          mdc_last;
   logic          mdc_rise;
   logic          bit_in;

   // strap capture
   logic [1:0]    strap_cnt;
   logic          strap_taken;
   logic          strap_load;

   // frame engine
   ppc_state_type state;
   logic [5:0]    ones;
   logic [3:0]    cnt;
   logic [10:0]   hdr;
   logic [11:0]   next_hdr;
   logic          op_read;
   logic          op_write;
   logic [15:0]   shout;
   logic [14:0]   wbuf;
   logic          wr;
   logic [4:0]    reg_addr;
   logic [15:0]   wdata;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         mdc_sync   <= 2'h0;
         mdio_sync  <= 2'h0;
         strap_sync <= 2'h0;
         addr_meta  <= 5'h00;
         addr_sync  <= 5'h00;
         mdc_last   <= 1'b0;
      end
      else
      begin
         mdc_sync   <= {mdc_sync[0], i_mdc};
         mdio_sync  <= {mdio_sync[0], i_mdio};
         strap_sync <= {strap_sync[0], i_power_down_strap_pin};
         addr_meta  <= i_phy_addr;
         addr_sync  <= addr_meta;
         mdc_last   <= mdc_sync[1];
      end
   end

   assign mdc_rise = mdc_sync[1] && !mdc_last;
   assign bit_in   = mdio_sync[1];
   assign next_hdr = {hdr, bit_in};

   // strap caught once the synchroniser holds the pin level
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         strap_cnt   <= 2'h0;
         strap_taken <= 1'b0;
      end
      else if (!strap_taken)
      begin
         if (strap_cnt == PPC_STRAP_WAIT)
            strap_taken <= 1'b1; // R5
         else
            strap_cnt <= strap_cnt + 2'h1;
      end
   end

   assign strap_load = !strap_taken && (strap_cnt == PPC_STRAP_WAIT);

   // frame sequencing, one step per mdc rising edge
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state    <= ST_PREAMBLE;
         ones     <= 6'h00;
         cnt      <= 4'h0;
         hdr      <= 11'h000;
         op_read  <= 1'b0;
         op_write <= 1'b0;
         reg_addr <= 5'h00;
         wbuf     <= 15'h0000;
      end
      else if (mdc_rise)
      begin
         unique case (state)
            ST_PREAMBLE:
            begin
               if (bit_in)
               begin
                  if (ones != PPC_PREAMBLE_ONES)
                     ones <= ones + 6'h01;
               end
               else if (ones == PPC_PREAMBLE_ONES)
                  state <= ST_START;
               else
                  ones <= 6'h00;
            end
            ST_START:
            begin
               ones <= 6'h00;
               cnt  <= 4'h0;
               // a second zero marks a clause 45 frame, not served here
               state <= bit_in ? ST_HEADER : ST_PREAMBLE;
            end
            ST_HEADER:
            begin
               hdr <= next_hdr[10:0];
               cnt <= cnt + 4'h1;
               if (cnt == PPC_HDR_LAST)
               begin
                  op_read  <= (next_hdr[11:10] == PPC_OP_READ)
                           && (next_hdr[9:5] == addr_sync);
                  op_write <= (next_hdr[11:10] == PPC_OP_WRITE)
                           && (next_hdr[9:5] == addr_sync);
                  reg_addr <= next_hdr[4:0];
                  cnt      <= 4'h0;
                  state    <= ST_TURN;
               end
            end
            ST_TURN:
            begin
               cnt <= cnt + 4'h1;
               if (cnt != 4'h0)
               begin
                  cnt   <= 4'h0;
                  state <= ST_DATA;
               end
            end
            ST_DATA:
            begin
               wbuf <= {wbuf[13:0], bit_in};
               cnt  <= cnt + 4'h1;
               if (cnt == PPC_DATA_LAST)
               begin
                  op_read  <= 1'b0;
                  op_write <= 1'b0;
                  state    <= ST_PREAMBLE;
               end
            end
         endcase
      end
   end

   // read data out; access works in every power state
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_mdio    <= 1'b0;
         o_mdio_oe <= 1'b0;
         shout     <= 16'h0000;
      end
      else if (mdc_rise && op_read)
      begin
         if (state == ST_TURN && cnt == 4'h0)
         begin
            o_mdio_oe <= 1'b1; // R4
            o_mdio    <= 1'b0;
            shout     <= mg.rdata; // R11
         end
         else if (state == ST_DATA && cnt == PPC_DATA_LAST)
         begin
            o_mdio_oe <= 1'b0;
            o_mdio    <= 1'b0;
         end
         else
         begin
            o_mdio <= shout[15];
            shout  <= {shout[14:0], 1'b0};
         end
      end
   end

   // write pulse after the last data bit
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr    <= 1'b0;
         wdata <= 16'h0000;
      end
      else
      begin
         wr <= mdc_rise && op_write && state == ST_DATA
            && cnt == PPC_DATA_LAST; // R4
         if (mdc_rise && state == ST_DATA && cnt == PPC_DATA_LAST)
            wdata <= {wbuf, bit_in};
      end
   end

   assign mg.wr    = wr;
   assign mg.addr  = reg_addr;
   assign mg.wdata = wdata;

   ppc_ctrl_bank u_bank
   (
      .i_clk            (i_clk),
      .i_rst            (i_rst),
      .mg               (mg.bank),
      .i_mir_wr         (i_mir_wr),
      .i_mir_sel        (i_mir_sel),
      .i_mir_bit        (i_mir_bit),
      .i_strap_load     (strap_load),
      .i_strap_value    (strap_sync[1]),
      .o_soft_reset     (o_soft_reset),
      .o_pcs_loopback   (o_pcs_loopback),
      .o_autoneg_enable (o_autoneg_enable),
      .o_power_down     (o_power_down),
      .o_mac_isolate    (o_mac_isolate)
   );

endmodule

// ===== tb/ppc_basic_control_monitor.sv
// Purpose: port assertions for the phy basic control block
// Assumes: one clock, async active-high reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
module ppc_basic_control_monitor
   import ppc_pkg::*;
(
   input wire logic           i_clk,
   input wire logic           i_rst,
   input wire logic           i_mdc,
   input wire logic           i_mdio,
   input wire logic           o_mdio,
   input wire logic           o_mdio_oe,
   input wire logic [4:0]     i_phy_addr,
   input wire logic           i_power_down_strap_pin,
   input wire logic           i_mir_wr,
   input wire ppc_mirror_type i_mir_sel,
   input wire logic           i_mir_bit,
   input wire logic           o_soft_reset,
   input wire logic           o_pcs_loopback,
   input wire logic           o_autoneg_enable,
   input wire logic           o_power_down,
   input wire logic           o_mac_isolate
);
   logic [8:0] sr_cnt;

   // length of the running soft reset cycle
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         sr_cnt <= 9'h000;
      else if (o_soft_reset)
         sr_cnt <= sr_cnt + 9'h001;
      else
         sr_cnt <= 9'h000;
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_drive_start;
      $rose(o_mdio_oe) ##0 !o_mdio;
   endsequence

   sequence s_sr_end;
      $fell(o_soft_reset);
   endsequence

   // the last soft reset cycle overrides mirror writes and a busy cycle ignores soft reset mirror writes, so skip those
   property p_mirror(ppc_mirror_type sel, logic q);
      i_mir_wr && i_mir_sel == sel && !o_soft_reset
         |=> q == $past(i_mir_bit);
   endproperty

   a_mirror_reset:
      assert property (p_mirror(MIR_SOFT_RESET, o_soft_reset))
      else $error("soft reset mirror write lost");
   a_mirror_loopback:
      assert property (p_mirror(MIR_PCS_LOOPBACK, o_pcs_loopback))
      else $error("loopback mirror write lost");
   a_mirror_autoneg:
      assert property (p_mirror(MIR_AUTONEG_ENABLE, o_autoneg_enable))
      else $error("autoneg mirror write lost");
   a_mirror_power:
      assert property (p_mirror(MIR_POWER_DOWN, o_power_down))
      else $error("power-down mirror write lost");
   a_soft_reset_len:
      assert property (s_sr_end |-> sr_cnt == PPC_SOFT_RESET_CYCLES)
      else $error("soft reset cycle has wrong length");
   a_soft_reset_end:
      assert property (s_sr_end |-> ##[0:1] (o_autoneg_enable
         && !o_pcs_loopback && !o_mac_isolate))
      else $error("soft reset did not restore defaults");
   a_drive_zero:
      assert property ($rose(o_mdio_oe) |-> !o_mdio)
      else $error("turnaround not driven low");
   a_drive_hold:
      assert property (s_drive_start |-> o_mdio_oe [*8])
      else $error("read drive dropped early");
   a_reset_values:
      assert property ($fell(i_rst) |-> o_autoneg_enable && !o_soft_reset
         && !o_pcs_loopback && !o_mac_isolate && !o_mdio_oe)
      else $error("wrong values after reset");
   a_strap_capture:
      assert property ($fell(i_rst)
         |-> ##4 (o_power_down == i_power_down_strap_pin))
      else $error("power-down strap not captured");
endmodule

bind ppc_phy_basic_control ppc_basic_control_monitor mon
(
   .i_clk                 (i_clk),
   .i_rst                 (i_rst),
   .i_mdc                 (i_mdc),
   .i_mdio                (i_mdio),
   .o_mdio                (o_mdio),
   .o_mdio_oe             (o_mdio_oe),
   .i_phy_addr            (i_phy_addr),
   .i_power_down_strap_pin(i_power_down_strap_pin),
   .i_mir_wr              (i_mir_wr),
   .i_mir_sel             (i_mir_sel),
   .i_mir_bit             (i_mir_bit),
   .o_soft_reset          (o_soft_reset),
   .o_pcs_loopback        (o_pcs_loopback),
   .o_autoneg_enable      (o_autoneg_enable),
   .o_power_down          (o_power_down),
   .o_mac_isolate         (o_mac_isolate)
);

// ===== tb/ppc_host_model.sv
// Purpose: management host driving clause 22 frames
// Assumes: mdc half period of 10 system clocks
// Notes:   mdc stands low between frames, line pulled up
`timescale 1ns/1ps
module ppc_host_model
   import ppc_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_dev_mdio,
   input  wire logic i_dev_oe,
   output logic      o_mdc,
   output logic      o_mdio
);
   logic host_oe;
   logic host_bit;

   // released line reads high through the pull-up
   assign o_mdio = i_dev_oe ? i_dev_mdio : (host_oe ? host_bit : 1'b1);

   initial
   begin
      o_mdc = 1'b0;
      host_oe = 1'b0;
      host_bit = 1'b1;
   end

   task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--)
      begin
         @(negedge i_clk);
         o_mdc = 1'b0;
         host_oe = (op == PPC_OP_WRITE) || (i > 17);
         host_bit = f[i];
         repeat (9) @(negedge i_clk);
         // sample late in the low half, after the device settled
         if (i < 16)
            rd[i] = o_mdio;
         @(negedge i_clk);
         o_mdc = 1'b1;
         repeat (9) @(negedge i_clk);
      end
      @(negedge i_clk);
      o_mdc = 1'b0;
      host_oe = 1'b0;
   endtask

   task automatic set_bits(input logic [4:0] phy, input logic [15:0] m);
      logic [15:0] v;
      xfer(PPC_OP_READ, phy, PPC_ADDR_BASIC_CONTROL, 16'h0000, v);
      xfer(PPC_OP_WRITE, phy, PPC_ADDR_BASIC_CONTROL, v | m, v);
   endtask
endmodule

// ===== tb/phy_basic_control_register_test.sv
// Purpose: self-checking bench for the phy basic control block
// Assumes: inputs change on the falling clock edge
// Notes:   phy address tied to one value
`timescale 1ns/1ps
module phy_basic_control_register_test
   import ppc_pkg::*;
   ;
   localparam logic [4:0] PHY = 5'h03;
   localparam logic [4:0] CTL = PPC_ADDR_BASIC_CONTROL;
   logic clk, rst, mdc, mdio_in, mdio_out, mdio_oe, strap;
   logic mir_wr, mir_bit, sr, lb, an, pd, iso, oe_seen;
   ppc_mirror_type mir_sel;
   logic [15:0] d;
   int num_errors, comparisons;
   wire logic [15:0] outs = {11'h000, sr, lb, an, pd, iso};

   ppc_phy_basic_control dut
   (
      .i_clk(clk), .i_rst(rst), .i_mdc(mdc), .i_mdio(mdio_in),
      .o_mdio(mdio_out), .o_mdio_oe(mdio_oe), .i_phy_addr(PHY),
      .i_power_down_strap_pin(strap), .i_mir_wr(mir_wr),
      .i_mir_sel(mir_sel), .i_mir_bit(mir_bit), .o_soft_reset(sr),
      .o_pcs_loopback(lb), .o_autoneg_enable(an), .o_power_down(pd),
      .o_mac_isolate(iso)
   );

   ppc_host_model host
   (
      .i_clk(clk), .i_dev_mdio(mdio_out), .i_dev_oe(mdio_oe),
      .o_mdc(mdc), .o_mdio(mdio_in)
   );

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk)
      if (mdio_oe === 1'b1)
         oe_seen = 1'b1;

   task automatic complete_run;
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] exp,
      input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
      host.xfer(PPC_OP_READ, PHY, ra, 16'h0000, d);
      check("mdio read", exp, d);
   endtask

   task automatic wr(input logic [4:0] ra, input logic [15:0] v);
      logic [15:0] x;
      host.xfer(PPC_OP_WRITE, PHY, ra, v, x);
   endtask

   task automatic mir(input ppc_mirror_type s, input logic b);
      mir_sel = s;
      mir_bit = b;
      mir_wr = 1'b1;
      @(negedge clk);
      mir_wr = 1'b0;
      @(negedge clk);
   endtask

   // bounded wait for the soft reset cycle to finish
   task automatic sr_wait;
      int n;
      n = 0;
      while (sr !== 1'b0 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 400)
      begin
         num_errors++;
         complete_run;
      end
   endtask

   task automatic reset_dut(input logic s);
      strap = s;
      rst = 1'b1;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      num_errors++;
      complete_run;
   end

   initial
   begin
      rst = 1'b1;
      strap = 1'b0;
      mir_wr = 1'b0;
      mir_sel = MIR_SOFT_RESET;
      mir_bit = 1'b0;
      oe_seen = 1'b0;
      num_errors = 0;
      comparisons = 0;
      reset_dut(1'b0);
      check("control outputs", 16'h0004, outs);
      rd(CTL, 16'h1100);
      wr(CTL, 16'h7fff);
      check("control outputs", 16'h000f, outs);
      rd(CTL, 16'h5d00);
      wr(CTL, 16'h0000);
      rd(CTL, 16'h1100);
      mir(MIR_AUTONEG_ENABLE, 1'b0);
      rd(CTL, 16'h0100);
      mir(MIR_AUTONEG_ENABLE, 1'b1);
      mir(MIR_PCS_LOOPBACK, 1'b1);
      mir(MIR_POWER_DOWN, 1'b1);
      rd(CTL, 16'h5900);
      rd(5'h01, 16'h0000);
      wr(5'h01, 16'hffff);
      rd(CTL, 16'h5900);
      oe_seen = 1'b0;
      host.xfer(PPC_OP_READ, 5'h04, CTL, 16'h0000, d);
      check("foreign read", 16'hffff, d);
      check("foreign drive", 16'h0000, {15'h0000, oe_seen});
      host.set_bits(PHY, 16'h8000);
      check("soft reset busy", 16'h0001, {15'h0000, sr});
      sr_wait;
      check("control outputs", 16'h0004, outs);
      rd(CTL, 16'h1100);
      mir(MIR_SOFT_RESET, 1'b1);
      check("soft reset busy", 16'h0001, {15'h0000, sr});
      sr_wait;
      reset_dut(1'b1);
      check("control outputs", 16'h0006, outs);
      rd(CTL, 16'h1900);
      complete_run;
   end
endmodule
